// file: pkg/chgreg_consts.vh
// Purpose: Constants for the charger status and control register block.
// Assumes: Avalon-MM word addressing, one 8-bit register per 32-bit word.
// Notes:   Offsets are printed register indices; byte address is four times.
`ifndef CHGREG_CONSTS_VH
`define CHGREG_CONSTS_VH

`define CHGREG_IDX_STATUS    4'h3
`define CHGREG_IDX_CONTROL   4'h4
`define CHGREG_IDX_IRQ_STAT  4'h8
`define CHGREG_IDX_IRQ_EN    4'h9
`define CHGREG_IDX_IRQ_CLR   4'ha

`define CHGREG_STATUS_RST    8'h00
`define CHGREG_CONTROL_RST   8'hb1
`define CHGREG_IRQ_EN_RST    8'h00

`define CHGREG_ST_THERMREG   7
`define CHGREG_ST_LOADPRIO   6
`define CHGREG_ST_THSUSP     5
`define CHGREG_ST_TERMCUR    4
`define CHGREG_ST_ACTIVE     3
`define CHGREG_ST_CHARGE_TIMEOUT_FLAG    2
`define CHGREG_ST_PRECHARGE_TIMEOUT_FLAG   1
`define CHGREG_ST_BATTERY_TEMP_FAULT_FLAG    0

`define CHGREG_CT_TIMER_HI   7
`define CHGREG_CT_TIMER_LO   6
`define CHGREG_CT_TMREN      5
`define CHGREG_CT_NTC        4
`define CHGREG_CT_RESTART    3
`define CHGREG_CT_TERMDIS    2
`define CHGREG_CT_SUSPEND    1
`define CHGREG_CT_CHGEN      0

`define CHGREG_HOURS_00      4'h4
`define CHGREG_HOURS_01      4'h5
`define CHGREG_HOURS_10      4'h6
`define CHGREG_HOURS_11      4'h8

`define CHGREG_SYNC_STAGES   2

`endif

// file: rtl/chgreg_irq.v
// Purpose: Sticky event bits with enable and write-one-to-clear.
// Assumes: Events are single-cycle pulses on sys_clk.
// Notes:   A set in the same cycle as its clear wins, so no event is lost.
`timescale 1ns/1ns
`default_nettype none
module chgreg_irq #(
    parameter WIDTH = 8
) (
    input  wire             sys_clk,
    input  wire             rstn,
    input  wire             clkEn,
    input  wire [WIDTH-1:0] eventIn,
    input  wire [WIDTH-1:0] clearIn,
    input  wire [WIDTH-1:0] enableIn,
    output wire [WIDTH-1:0] stickyOut,
    output wire             irqNext
);
    reg  [WIDTH-1:0] sticky_ff;
    wire [WIDTH-1:0] nxt_sticky;
    genvar i;
    generate
        for (i = 0; i < WIDTH; i = i + 1) begin : gBit
            assign nxt_sticky[i] = eventIn[i] | (sticky_ff[i] & ~clearIn[i]);
        end
    endgenerate
    always @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            sticky_ff <= {WIDTH{1'b0}};
        end else if (clkEn) begin
            sticky_ff <= nxt_sticky;
        end
    end
    assign stickyOut = sticky_ff;
    // Computed from the next value so that the top's flop matches sticky timing.
    assign irqNext   = |(nxt_sticky & enableIn);
endmodule // chgreg_irq
`default_nettype wire

// file: rtl/chgreg_sync.v
// Purpose: Two-flop synchroniser for a bank of asynchronous status levels.
// Assumes: Inputs are slow analog comparator levels.
// Notes:   The first stage is read only by the second stage.
`timescale 1ns/1ns
`default_nettype none
module chgreg_sync #(
    parameter WIDTH = 8
) (
    input  wire             sys_clk,
    input  wire             rstn,
    input  wire             clkEn,
    input  wire [WIDTH-1:0] asyncIn,
    output wire [WIDTH-1:0] syncOut
);
    reg [WIDTH-1:0] meta_ff;
    reg [WIDTH-1:0] sync_ff;
    genvar i;
    generate
        for (i = 0; i < WIDTH; i = i + 1) begin : gBit
            always @(posedge sys_clk or negedge rstn) begin
                if (!rstn) begin
                    meta_ff[i] <= 1'b0;
                    sync_ff[i] <= 1'b0;
                end else if (clkEn) begin
                    meta_ff[i] <= asyncIn[i];
                    sync_ff[i] <= meta_ff[i];
                end
            end
        end
    endgenerate
    assign syncOut = sync_ff;
endmodule // chgreg_sync
`default_nettype wire

// file: rtl/chgreg_top.v
// Purpose: Charger status and control register bank on Avalon-MM.
// Assumes: Charger analog indications arrive asynchronously on pins.
// Notes:   Registers are 8 bits wide in the low byte of each 32-bit word.
// Notes on behaviour
// - status at index 0x03, resets to zero
// - bit 7 shows thermal current reduction
// - bit 6 shows load-priority loop active
// - bit 5 shows thermal charge suspend
// - bit 4 shows termination current crossed, stopped
// - bit 3 shows charger actively charging
// - bit 2 shows charge timer expired
// - bit 1 shows precharge timer expired
// - bit 0 shows sensor missing or temperature fault
// - control at index 0x04, resets to 0xb1
// - bits 7:6 pick safety timer hours
// - bit 5 enables both charge timers
// - bit 4 picks thermistor curve
// - bit 3 holds charger in reset
// - bit 2 disables current-based termination
// - bit 1 freezes timers without clearing
// - bit 0 enables the charger
`timescale 1ns/1ns
`default_nettype none
`include "chgreg_consts.vh"
module chgreg_top #(
    parameter ADDR_W = 4
) (
    input  wire              sys_clk,
    input  wire              rstn,
    input  wire              clkEn,
    input  wire [ADDR_W-1:0] avsAddress,
    input  wire              avsRead,
    input  wire              avsWrite,
    input  wire [31:0]       avsWritedata,
    input  wire [3:0]        avsByteenable,
    output reg  [31:0]       avsReaddata,
    output reg               avsWaitrequest,
    output reg  [1:0]        avsResponse,
    input  wire              thermalRegPin,
    input  wire              loadPrioPin,
    input  wire              thermalSuspPin,
    input  wire              termCurrentPin,
    input  wire              chargingPin,
    input  wire              chgTimeoutPin,
    input  wire              pchgTimeoutPin,
    input  wire              battTempFaultPin,
    output reg  [1:0]        safetyTimerSel,
    output reg  [3:0]        safetyTimerHours,
    output reg               safetyTimersEnable,
    output reg               thermistorTypeSelect,
    output reg               chargerReset,
    output reg               termDisable,
    output reg               timerSuspend,
    output reg               chargerEnable,
    output reg               irq
);
    localparam ST_IDLE = 2'b01;
    localparam ST_DONE = 2'b10;

    reg  [1:0]  state_ff;
    reg  [7:0]  status_ff;
    reg  [7:0]  control_ff;
    reg  [7:0]  irqEn_ff;
    reg  [7:0]  prevStatus_ff;
    wire [7:0]  statusRaw;
    wire [7:0]  sticky;
    wire [7:0]  rises;
    wire        irqNext;
    reg  [7:0]  clearPulse;
    reg  [31:0] nxt_readdata;
    reg  [1:0]  nxt_response;
    reg  [3:0]  nxt_hours;

    wire req    = avsRead | avsWrite;
    wire acking = (state_ff == ST_IDLE) & req;
    wire wrLow  = acking & avsWrite & avsByteenable[0];

    chgreg_sync #(
        .WIDTH (8)
    ) uSync (
        .sys_clk (sys_clk),
        .rstn    (rstn),
        .clkEn   (clkEn),
        .asyncIn ({thermalRegPin, loadPrioPin, thermalSuspPin, termCurrentPin,
                   chargingPin, chgTimeoutPin, pchgTimeoutPin, battTempFaultPin}),
        .syncOut (statusRaw)
    );

    // Status mirrors live conditions; no read or write alters it.
    always @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            status_ff     <= `CHGREG_STATUS_RST;
            prevStatus_ff <= `CHGREG_STATUS_RST;
        end else if (clkEn) begin
            status_ff[`CHGREG_ST_THERMREG] <= statusRaw[7];
            status_ff[`CHGREG_ST_LOADPRIO] <= statusRaw[6];
            status_ff[`CHGREG_ST_THSUSP]   <= statusRaw[5];
            status_ff[`CHGREG_ST_TERMCUR]  <= statusRaw[4];
            status_ff[`CHGREG_ST_ACTIVE]   <= statusRaw[3];
            status_ff[`CHGREG_ST_CHARGE_TIMEOUT_FLAG]  <= statusRaw[2];
            status_ff[`CHGREG_ST_PRECHARGE_TIMEOUT_FLAG] <= statusRaw[1];
            status_ff[`CHGREG_ST_BATTERY_TEMP_FAULT_FLAG]  <= statusRaw[0];
            prevStatus_ff <= status_ff;
        end
    end

    // Each rising status flag is an interrupt event.
    assign rises = status_ff & ~prevStatus_ff;

    always @* begin
        clearPulse = 8'h00;
        if (wrLow && avsAddress == `CHGREG_IDX_IRQ_CLR) begin
            clearPulse = avsWritedata[7:0];
        end
    end

    chgreg_irq #(
        .WIDTH (8)
    ) uIrq (
        .sys_clk   (sys_clk),
        .rstn      (rstn),
        .clkEn     (clkEn),
        .eventIn   (rises),
        .clearIn   (clearPulse),
        .enableIn  (irqEn_ff),
        .stickyOut (sticky),
        .irqNext   (irqNext)
    );

    always @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            control_ff <= `CHGREG_CONTROL_RST;
            irqEn_ff   <= `CHGREG_IRQ_EN_RST;
        end else if (clkEn && wrLow) begin
            // Writes to the status index fall through and are dropped.
            if (avsAddress == `CHGREG_IDX_CONTROL) begin
                control_ff <= avsWritedata[7:0];
            end
            if (avsAddress == `CHGREG_IDX_IRQ_EN) begin
                irqEn_ff <= avsWritedata[7:0];
            end
        end
    end

    always @* begin
        nxt_readdata = 32'h0000_0000;
        nxt_response = 2'b00;
        case (avsAddress)
            `CHGREG_IDX_STATUS:   nxt_readdata[7:0] = status_ff;
            `CHGREG_IDX_CONTROL:  nxt_readdata[7:0] = control_ff;
            `CHGREG_IDX_IRQ_STAT: nxt_readdata[7:0] = sticky;
            `CHGREG_IDX_IRQ_EN:   nxt_readdata[7:0] = irqEn_ff;
            `CHGREG_IDX_IRQ_CLR:  nxt_readdata[7:0] = 8'h00;
            default:              nxt_response = 2'b11;
        endcase
    end

    // One wait cycle: waitrequest drops in the cycle after the request appears.
    always @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            state_ff       <= ST_IDLE;
            avsWaitrequest <= 1'b1;
            avsReaddata    <= 32'h0000_0000;
            avsResponse    <= 2'b00;
        end else if (clkEn) begin
            case (state_ff)
                ST_IDLE: begin
                    if (req) begin
                        state_ff       <= ST_DONE;
                        avsWaitrequest <= 1'b0;
                        avsReaddata    <= avsRead ? nxt_readdata : 32'h0000_0000;
                        avsResponse    <= nxt_response;
                    end
                end
                ST_DONE: begin
                    state_ff       <= ST_IDLE;
                    avsWaitrequest <= 1'b1;
                    avsResponse    <= 2'b00;
                end
                default: begin
                    state_ff       <= ST_IDLE;
                    avsWaitrequest <= 1'b1;
                end
            endcase
        end
    end

    always @* begin
        case (control_ff[`CHGREG_CT_TIMER_HI:`CHGREG_CT_TIMER_LO])
            2'b00:   nxt_hours = `CHGREG_HOURS_00;
            2'b01:   nxt_hours = `CHGREG_HOURS_01;
            2'b10:   nxt_hours = `CHGREG_HOURS_10;
            default: nxt_hours = `CHGREG_HOURS_11;
        endcase
    end

    // Control outputs are flopped once more so every output is a register.
    always @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            safetyTimerSel       <= 2'b10;
            safetyTimerHours     <= `CHGREG_HOURS_10;
            safetyTimersEnable   <= 1'b1;
            thermistorTypeSelect <= 1'b1;
            chargerReset         <= 1'b0;
            termDisable          <= 1'b0;
            timerSuspend         <= 1'b0;
            chargerEnable        <= 1'b1;
            irq                  <= 1'b0;
        end else if (clkEn) begin
            safetyTimerSel       <= control_ff[`CHGREG_CT_TIMER_HI:`CHGREG_CT_TIMER_LO];
            safetyTimerHours     <= nxt_hours;
            safetyTimersEnable   <= control_ff[`CHGREG_CT_TMREN];
            thermistorTypeSelect <= control_ff[`CHGREG_CT_NTC];
            chargerReset         <= control_ff[`CHGREG_CT_RESTART];
            termDisable          <= control_ff[`CHGREG_CT_TERMDIS];
            timerSuspend         <= control_ff[`CHGREG_CT_SUSPEND];
            chargerEnable        <= control_ff[`CHGREG_CT_CHGEN];
            irq                  <= irqNext;
        end
    end
endmodule // chgreg_top
`default_nettype wire

// file: tb/chgreg_top_assertions.sv
// Purpose: Bus and control-output checks for the charger register bank.
// Assumes: The slave acknowledges one cycle after it sees a request.
// Notes:   Sees only top-level ports and is bound below.
`timescale 1ns/1ns
`default_nettype none
module chgreg_top_assertions #(
    parameter ADDR_W = 4
) (
    input wire logic              sys_clk,
    input wire logic              rstn,
    input wire logic [ADDR_W-1:0] avsAddress,
    input wire logic              avsRead,
    input wire logic              avsWrite,
    input wire logic [31:0]       avsWritedata,
    input wire logic [3:0]        avsByteenable,
    input wire logic [31:0]       avsReaddata,
    input wire logic              avsWaitrequest,
    input wire logic [1:0]        avsResponse,
    input wire logic [1:0]        safetyTimerSel,
    input wire logic [3:0]        safetyTimerHours,
    input wire logic              safetyTimersEnable,
    input wire logic              thermistorTypeSelect,
    input wire logic              chargerReset,
    input wire logic              termDisable,
    input wire logic              timerSuspend,
    input wire logic              chargerEnable
);
    wire logic [7:0] ctrlOut;
    wire logic       mapped;
    assign ctrlOut = {safetyTimerSel, safetyTimersEnable, thermistorTypeSelect,
                      chargerReset, termDisable, timerSuspend, chargerEnable};
    assign mapped = avsAddress inside {4'h3, 4'h4, 4'h8, 4'h9, 4'ha};
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rstn);
    sequence s_ack;
        !avsWaitrequest;
    endsequence
    sequence s_ctrl_ack;
        avsWrite && avsAddress == 4'h4 && avsByteenable[0] && !avsWaitrequest;
    endsequence
    chk_ack_single: assert property (s_ack |=> avsWaitrequest)
        else $error("Acknowledge lasted more than one cycle");
    chk_ack_cause: assert property ($fell(avsWaitrequest) |-> $past(avsRead || avsWrite))
        else $error("Acknowledge without a request");
    chk_req_answered: assert property ((avsRead || avsWrite) |-> ##[0:3] s_ack)
        else $error("Request not acknowledged in time");
    chk_ctrl_write: assert property (s_ctrl_ack |=> ctrlOut == $past(avsWritedata[7:0]))
        else $error("Control outputs do not follow the write");
    chk_ctrl_hold: assert property ($changed(ctrlOut) |-> $past(avsWrite && avsAddress == 4'h4 && !avsWaitrequest))
        else $error("Control outputs changed without a write");
    chk_ctrl_reset: assert property ($rose(rstn) |-> ctrlOut == 8'hb1)
        else $error("Control outputs wrong after reset");
    chk_hours_map: assert property (safetyTimerHours == (safetyTimerSel == 2'b00 ? 4'h4 : safetyTimerSel == 2'b01 ? 4'h5 : safetyTimerSel == 2'b10 ? 4'h6 : 4'h8))
        else $error("Timer hours do not match the selection");
    chk_decode_err: assert property (s_ack and !mapped |-> avsResponse == 2'b11)
        else $error("Unmapped access not refused");
    chk_decode_ok: assert property (s_ack and mapped |-> avsResponse == 2'b00 && avsReaddata[31:8] == 24'h0)
        else $error("Mapped access answered wrongly");
endmodule // chgreg_top_assertions
bind chgreg_top chgreg_top_assertions #(.ADDR_W(ADDR_W)) u_chk (
    .sys_clk(sys_clk), .rstn(rstn), .avsAddress(avsAddress), .avsRead(avsRead),
    .avsWrite(avsWrite), .avsWritedata(avsWritedata), .avsByteenable(avsByteenable),
    .avsReaddata(avsReaddata), .avsWaitrequest(avsWaitrequest), .avsResponse(avsResponse),
    .safetyTimerSel(safetyTimerSel), .safetyTimerHours(safetyTimerHours),
    .safetyTimersEnable(safetyTimersEnable), .thermistorTypeSelect(thermistorTypeSelect),
    .chargerReset(chargerReset), .termDisable(termDisable), .timerSuspend(timerSuspend),
    .chargerEnable(chargerEnable));
`default_nettype wire

// file: tb/chgreg_top_tb.sv
// Purpose: Self-checking bench for the charger register bank.
// Assumes: Status pins reach the register within six cycles.
// Notes:   Bus answers are checked by a monitor against queued notes.
`timescale 1ns/1ns
`default_nettype none
module chgreg_top_tb;
    logic        sys_clk, rstn, clkEn, avsRead, avsWrite;
    logic [3:0]  avsAddress, avsByteenable;
    logic [31:0] avsWritedata;
    logic [7:0]  pinVec, v;
    wire  [31:0] avsReaddata;
    wire  [1:0]  avsResponse, safetyTimerSel;
    wire  [3:0]  safetyTimerHours;
    wire         avsWaitrequest, safetyTimersEnable, thermistorTypeSelect, chargerReset;
    wire         termDisable, timerSuspend, chargerEnable, irq;
    wire  [7:0]  ctrlOut = {safetyTimerSel, safetyTimersEnable, thermistorTypeSelect,
                            chargerReset, termDisable, timerSuspend, chargerEnable};
    integer      seed, failures, tests_run, i;
    logic [34:0] notes[$];
    chgreg_top #(.ADDR_W(4)) i_dut (
        .sys_clk(sys_clk), .rstn(rstn), .clkEn(clkEn), .avsAddress(avsAddress),
        .avsRead(avsRead), .avsWrite(avsWrite), .avsWritedata(avsWritedata),
        .avsByteenable(avsByteenable), .avsReaddata(avsReaddata),
        .avsWaitrequest(avsWaitrequest), .avsResponse(avsResponse),
        .thermalRegPin(pinVec[7]), .loadPrioPin(pinVec[6]), .thermalSuspPin(pinVec[5]),
        .termCurrentPin(pinVec[4]), .chargingPin(pinVec[3]), .chgTimeoutPin(pinVec[2]),
        .pchgTimeoutPin(pinVec[1]), .battTempFaultPin(pinVec[0]),
        .safetyTimerSel(safetyTimerSel), .safetyTimerHours(safetyTimerHours),
        .safetyTimersEnable(safetyTimersEnable), .thermistorTypeSelect(thermistorTypeSelect),
        .chargerReset(chargerReset), .termDisable(termDisable), .timerSuspend(timerSuspend),
        .chargerEnable(chargerEnable), .irq(irq));
    initial begin
        sys_clk = 1'b0;
        forever #2 sys_clk = ~sys_clk;
    end
    task automatic tally_and_finish;
        if (failures == 0 && tests_run > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    task automatic check_bus(input logic [34:0] n);
        tests_run++;
        if (avsResponse !== n[33:32] || (n[34] && n[33:32] == 2'b00 && avsReaddata !== n[31:0])) begin
            failures++;
            $display("Error %0t: bus answer %h %h, expected %h", $time, avsResponse, avsReaddata, n);
        end
    endtask
    task automatic check_out(input logic [7:0] got, input logic [7:0] exp);
        tests_run++;
        if (got !== exp) begin
            failures++;
            $display("Error %0t: output %h, expected %h", $time, got, exp);
        end
    endtask
    function automatic logic [7:0] hoursOf(input logic [1:0] s);
        return (s == 2'b00) ? 8'h04 : (s == 2'b01) ? 8'h05 : (s == 2'b10) ? 8'h06 : 8'h08;
    endfunction
    // The request is held until waitrequest is seen low; one idle edge follows it.
    task automatic xfer(input logic rd, input logic [3:0] a, input logic [7:0] d,
                        input logic [3:0] be, input logic [1:0] rsp, input logic [7:0] ex);
        integer      n;
        logic [31:0] r;
        n = 0;
        r = $random(seed);
        notes.push_back({rd, rsp, 24'h0, ex});
        avsAddress <= a;
        avsWritedata <= {r[23:0], d};
        avsByteenable <= be;
        avsRead <= rd;
        avsWrite <= !rd;
        do begin
            @(posedge sys_clk);
            n++;
        end while (avsWaitrequest !== 1'b0 && n < 20);
        if (n >= 20) failures++;
        avsRead <= 1'b0;
        avsWrite <= 1'b0;
        @(posedge sys_clk);
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        xfer(1'b0, a, d, 4'hf, 2'b00, 8'h00);
    endtask
    task automatic rdc(input logic [3:0] a, input logic [7:0] ex);
        xfer(1'b1, a, 8'h00, 4'hf, 2'b00, ex);
    endtask
    always @(posedge sys_clk) begin
        if ((avsRead || avsWrite) && avsWaitrequest === 1'b0) check_bus(notes.pop_front());
    end
    initial begin
        repeat (20000) @(posedge sys_clk);
        failures++;
        tally_and_finish;
    end
    initial begin
        seed = 32'he94913a1;
        failures = 0;
        tests_run = 0;
        {rstn, avsRead, avsWrite, avsAddress, avsByteenable, avsWritedata, pinVec} = '0;
        clkEn = 1'b1;
        repeat (4) @(posedge sys_clk);
        rstn <= 1'b1;
        @(posedge sys_clk);
        check_out(ctrlOut, 8'hb1);
        check_out(hoursOf(safetyTimerSel), {4'h0, safetyTimerHours});
        rdc(4'h3, 8'h00);
        rdc(4'h4, 8'hb1);
        for (i = 0; i < 8; i++) begin
            pinVec <= 8'h01 << i;
            repeat (6) @(posedge sys_clk);
            rdc(4'h3, 8'h01 << i);
        end
        check_out({7'h0, irq}, 8'h00);
        rdc(4'h8, 8'hff);
        rdc(4'h8, 8'hff);
        wr(4'h9, 8'h10);
        check_out({7'h0, irq}, 8'h01);
        wr(4'ha, 8'h10);
        check_out({7'h0, irq}, 8'h00);
        rdc(4'h8, 8'hef);
        wr(4'h3, 8'h00);
        rdc(4'h3, 8'h80);
        xfer(1'b1, 4'h5, 8'h00, 4'hf, 2'b11, 8'h00);
        xfer(1'b0, 4'h4, 8'h00, 4'he, 2'b00, 8'h00);
        rdc(4'h4, 8'hb1);
        // Every timer code is used, and the restart bit is set and cleared.
        for (i = 0; i < 8; i++) begin
            v = $random(seed);
            v[7:6] = i[1:0];
            v[3] = i[2];
            wr(4'h4, v);
            check_out(ctrlOut, v);
            check_out(hoursOf(v[7:6]), {4'h0, safetyTimerHours});
            rdc(4'h4, v);
        end
        v = $random(seed);
        pinVec <= v;
        repeat (6) @(posedge sys_clk);
        rdc(4'h3, v);
        // A frozen block must still show the old status in the first cycle it runs again.
        clkEn <= 1'b0;
        pinVec <= ~v;
        repeat (8) @(posedge sys_clk);
        clkEn <= 1'b1;
        rdc(4'h3, v);
        repeat (6) @(posedge sys_clk);
        rdc(4'h3, ~v);
        // A reset in mid-run must bring back the control, timer hours, irq output and status reset values.
        rstn <= 1'b0;
        repeat (2) @(posedge sys_clk);
        rstn <= 1'b1;
        @(posedge sys_clk);
        check_out(ctrlOut, 8'hb1);
        check_out(hoursOf(safetyTimerSel), {4'h0, safetyTimerHours});
        check_out({7'h0, irq}, 8'h00);
        rdc(4'h3, 8'h00);
        rdc(4'h4, 8'hb1);
        tally_and_finish;
    end
endmodule // chgreg_top_tb
`default_nettype wire
